/* File: hdl/sac_pkg.sv */
// package: register map, field positions, timing counts and state types of the converter control
package sac_pkg;
  // register byte offsets
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] START_OFS  = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS   = 8'h0C;
  localparam logic [7:0] STAT_OFS   = 8'h10;
  // field positions
  localparam int CKS_BIT    = 7;
  localparam int EXT_TRIGGER_ENABLE_BIT   = 6;
  localparam int FLAG_BIT   = 7;
  localparam int POL_BIT    = 0;
  localparam int PINSEL_BIT = 1;
  localparam int IRQEN_BIT  = 2;
  localparam int DONE_BIT   = 0;
  // reserved patterns and reset values
  localparam logic [7:0] MODE_RSVD  = 8'h30;
  localparam logic [7:0] START_RSVD = 8'h7F;
  localparam logic [3:0] CH_RST     = 4'h0;
  // conversion timing in phi states
  localparam logic [5:0] STATES_SLOW  = 6'h3E;
  localparam logic [5:0] STATES_FAST  = 6'h1F;
  localparam logic [3:0] SAMPLE_TICKS = 4'h2;
  localparam int         RES_BITS     = 10;
  localparam logic [9:0] SAR_MSB      = 10'h200;
  // channel codes
  localparam logic [3:0] CH_AN0 = 4'h4;
  localparam logic [3:0] CH_AN1 = 4'h5;
  localparam logic [3:0] CH_AN2 = 4'h6;

  typedef enum logic {PH_IDLE, PH_CONV} sac_phase_type;

  // drive toward the analog sampling core
  typedef struct packed {
    logic       sample;
    logic [2:0] chan_sel;
    logic [9:0] trial;
  } sac_analog_type;

  typedef struct packed {
    logic          conv_clock_select;
    logic          ext_trigger_enable;
    logic [3:0]    ch;
    logic          pol;
    logic          pinsel;
    logic          irqen;
    logic          done;
    sac_phase_type phase;
    logic [9:0]    sar;
    logic [9:0]    result;
    logic [5:0]    cnt;
    logic [1:0]    trg_sync;
    logic          trg_prev;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    waddr;
    logic [7:0]    wdata;
    logic          wlane0;
    logic          bvalid;
    logic          bslv;
    logic          rvalid;
    logic          rslv;
    logic [31:0]   rdata;
  } sac_state_type;
endpackage : sac_pkg

/* File: hdl/sac_adc_ctrl.sv */
// module: register interface and sequencing of a 10-bit successive-approximation converter
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module sac_adc_ctrl (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // low-power retention request
  input  wire logic                    hold_i,
  // axi4-lite write address and data
  input  wire logic                    s_axi_awvalid,
  output      logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output      logic                    s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // axi4-lite write response
  output      logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output      logic [1:0]              s_axi_bresp,
  // axi4-lite read
  input  wire logic                    s_axi_arvalid,
  output      logic                    s_axi_arready,
  input  wire logic [31:0]             s_axi_araddr,
  output      logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output      logic [31:0]             s_axi_rdata,
  output      logic [1:0]              s_axi_rresp,
  // analog core and trigger pin
  input  wire logic                    comp_i,
  input  wire logic                    ext_trigger_pin_i,
  output      sac_pkg::sac_analog_type analog_o,
  // conversion-end interrupt request
  output      logic                    conv_irq_o
);

  sac_pkg::sac_state_type st_r;
  sac_pkg::sac_state_type st_nxt;

  // channel field decode; prohibited and empty codes connect nothing
  function automatic logic [2:0] chan_decode(input logic [3:0] ch);
    logic [2:0] sel;
    sel = 3'h0;
    case (ch)
      sac_pkg::CH_AN0: sel = 3'h1;
      sac_pkg::CH_AN1: sel = 3'h2;
      sac_pkg::CH_AN2: sel = 3'h4;
      default:         sel = 3'h0;
    endcase
    return sel;
  endfunction : chan_decode

  // one approximation step: keep or drop the trial bit, then try the next lower one
  function automatic logic [9:0] sar_step(input logic [9:0] sar, input logic [3:0] bidx,
                                          input logic keep);
    logic [9:0] res;
    res = sar;
    if (!keep)
    begin
      res[bidx] = 1'b0;
    end
    if (bidx != 4'h0)
    begin
      res[bidx - 4'h1] = 1'b1;
    end
    return res;
  endfunction : sar_step

  logic       aw_hs;
  logic       w_hs;
  logic       do_wr;
  logic       ar_hs;
  logic       trg_edge;
  logic       trg_start;
  logic [5:0] last_cnt;
  logic [3:0] tick_idx;
  logic       tick_end;
  logic [3:0] bit_idx;
  logic       sw_start;
  logic       sw_abort;
  logic       finish;
  logic [31:0] rd_val;
  logic       rd_ok;
  logic [7:0] raddr;

  // handshake outputs straight from state so the master sees them without delay
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bslv ? 2'h2 : 2'h0;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rslv ? 2'h2 : 2'h0;
  assign conv_irq_o    = st_r.done && st_r.irqen;

  // analog drive; one process so the struct port has a single driver
  always_comb
  begin
    analog_o.trial    = st_r.sar;
    analog_o.chan_sel = (st_r.phase == sac_pkg::PH_CONV) ? chan_decode(st_r.ch) : 3'h0;
    analog_o.sample   = (st_r.phase == sac_pkg::PH_CONV) &&
                        (tick_idx < sac_pkg::SAMPLE_TICKS);
  end

  // bus event decode
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid && !hold_i; // latched copy only
  assign raddr = s_axi_araddr[7:0];

  // edge detect only on the second synchroniser stage
  assign trg_edge  = st_r.pol ? (!st_r.trg_sync[1] && st_r.trg_prev)
                              : (st_r.trg_sync[1] && !st_r.trg_prev);
  assign trg_start = trg_edge && st_r.ext_trigger_enable && st_r.pinsel;

  // sequencing: slow clock ticks every 4 states, fast every 2
  assign last_cnt = st_r.conv_clock_select ? (sac_pkg::STATES_FAST - 6'h1)
                             : (sac_pkg::STATES_SLOW - 6'h1);
  assign tick_idx = st_r.conv_clock_select ? st_r.cnt[4:1] : st_r.cnt[5:2];
  assign tick_end = st_r.conv_clock_select ? st_r.cnt[0] : (st_r.cnt[1:0] == 2'h3);
  assign bit_idx  = 4'(sac_pkg::RES_BITS + 1) - tick_idx;

  // write-side effects on the conversion flag
  assign sw_start = do_wr && (st_r.waddr == sac_pkg::START_OFS) && st_r.wlane0 &&
                    st_r.wdata[sac_pkg::FLAG_BIT];
  assign sw_abort = do_wr && (st_r.waddr == sac_pkg::START_OFS) && st_r.wlane0 &&
                    !st_r.wdata[sac_pkg::FLAG_BIT];
  assign finish   = (st_r.phase == sac_pkg::PH_CONV) && (st_r.cnt == last_cnt) && !sw_abort;

  // read mux; reserved bits of the mode and start registers return ones, other unused bits zero
  always_comb
  begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    case (raddr)
      sac_pkg::MODE_OFS:   rd_val[7:0] = {st_r.conv_clock_select, st_r.ext_trigger_enable, 2'h0, st_r.ch} |
                                         sac_pkg::MODE_RSVD;
      sac_pkg::START_OFS:  rd_val[7:0] = {st_r.phase == sac_pkg::PH_CONV, 7'h0} |
                                         sac_pkg::START_RSVD;
      sac_pkg::RESULT_OFS: rd_val[15:0] = {st_r.result, 6'h00};
      sac_pkg::CTRL_OFS:   rd_val[2:0] = {st_r.irqen, st_r.pinsel, st_r.pol};
      sac_pkg::STAT_OFS:   rd_val[0] = st_r.done;
      default:             rd_ok = 1'b0;
    endcase
  end

  // next-state logic for the whole block
  always_comb
  begin
    st_nxt = st_r;
    // bus channels keep running in retention so the master is never stuck
    if (aw_hs)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr  = s_axi_awaddr[7:0];
    end
    if (w_hs)
    begin
      st_nxt.w_got  = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    // answer once both halves are latched; the register update reads that latched copy
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bslv   = !(st_r.waddr inside {sac_pkg::MODE_OFS, sac_pkg::START_OFS,
                        sac_pkg::RESULT_OFS, sac_pkg::CTRL_OFS, sac_pkg::STAT_OFS});
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (ar_hs)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rslv   = !rd_ok;
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (!hold_i)
    begin
      st_nxt.trg_sync = {st_r.trg_sync[0], ext_trigger_pin_i};
      st_nxt.trg_prev = st_r.trg_sync[1];
      if (do_wr && st_r.wlane0)
      begin
        case (st_r.waddr)
          sac_pkg::MODE_OFS:
          begin
            st_nxt.conv_clock_select  = st_r.wdata[sac_pkg::CKS_BIT];
            st_nxt.ext_trigger_enable = st_r.wdata[sac_pkg::EXT_TRIGGER_ENABLE_BIT];
            st_nxt.ch   = st_r.wdata[3:0];
          end
          sac_pkg::CTRL_OFS:
          begin
            st_nxt.pol    = st_r.wdata[sac_pkg::POL_BIT];
            st_nxt.pinsel = st_r.wdata[sac_pkg::PINSEL_BIT];
            st_nxt.irqen  = st_r.wdata[sac_pkg::IRQEN_BIT];
          end
          sac_pkg::STAT_OFS:
          begin
            if (st_r.wdata[sac_pkg::DONE_BIT])
            begin
              st_nxt.done = 1'b0;
            end
          end
          default:
          begin
          end
        endcase
      end
      case (st_r.phase)
        sac_pkg::PH_IDLE:
        begin
          if (sw_start || (trg_start && !sw_abort))
          begin
            st_nxt.phase = sac_pkg::PH_CONV;
            st_nxt.cnt   = 6'h0;
            st_nxt.sar   = sac_pkg::SAR_MSB;
          end
        end
        sac_pkg::PH_CONV:
        begin
          st_nxt.cnt = st_r.cnt + 6'h1;
          if (sw_abort)
          begin
            st_nxt.phase = sac_pkg::PH_IDLE;
          end
          else if (finish)
          begin
            st_nxt.phase  = sac_pkg::PH_IDLE;
            st_nxt.result = st_r.sar;
            st_nxt.done   = 1'b1; // set wins over a same-cycle clear
          end
          else if (tick_end && tick_idx >= sac_pkg::SAMPLE_TICKS &&
                   bit_idx < 4'(sac_pkg::RES_BITS))
          begin
            st_nxt.sar = sar_step(st_r.sar, bit_idx, comp_i);
          end
        end
        default: st_nxt.phase = sac_pkg::PH_IDLE;
      endcase
    end
  end

  // state register; result kept across reset, control state cleared
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r          <= '0;
      st_r.ch       <= sac_pkg::CH_RST;
      st_r.phase    <= sac_pkg::PH_IDLE;
      st_r.result   <= st_r.result;
      st_r.trg_sync <= st_r.trg_sync;
      st_r.trg_prev <= st_r.trg_prev;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // checks on the sequencer, retention and the start register read
  conv_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.phase == sac_pkg::PH_CONV && !st_r.conv_clock_select |-> st_r.cnt < sac_pkg::STATES_SLOW)
    else $error("slow conversion overran");
  fast_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.phase == sac_pkg::PH_CONV && st_r.conv_clock_select |-> st_r.cnt < sac_pkg::STATES_FAST)
    else $error("fast conversion overran");
  trg_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.phase == sac_pkg::PH_IDLE && !st_r.ext_trigger_enable && !sw_start && !hold_i
    |=> st_r.phase == sac_pkg::PH_IDLE) else $error("start without enable");
  done_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    finish && !hold_i |=> st_r.phase == sac_pkg::PH_IDLE && st_r.done &&
    st_r.result == $past(st_r.sar)) else $error("completion did not load result");
  abort_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.phase == sac_pkg::PH_CONV && sw_abort && !hold_i
    |=> st_r.phase == sac_pkg::PH_IDLE && $stable(st_r.result)) else $error("abort ignored");
  sw_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.phase == sac_pkg::PH_IDLE && sw_start && !hold_i
    |=> st_r.phase == sac_pkg::PH_CONV && st_r.cnt == 6'h0) else $error("start lost");
  pin_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.phase == sac_pkg::PH_IDLE && trg_start && !do_wr && !hold_i
    |=> st_r.phase == sac_pkg::PH_CONV) else $error("trigger edge lost");
  irq_tie_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    finish && st_r.irqen && !do_wr && !hold_i |=> conv_irq_o)
    else $error("no conversion interrupt");
  hold_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hold_i |=> $stable({st_r.conv_clock_select, st_r.ext_trigger_enable, st_r.ch, st_r.phase, st_r.cnt}))
    else $error("state moved in retention");
  rsvd_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ar_hs && raddr == sac_pkg::START_OFS |=> s_axi_rdata[6:0] == 7'h7F)
    else $error("reserved bits not one");

  slow_done_c: cover property (@(posedge clk_i) finish && !st_r.conv_clock_select);
  fast_done_c: cover property (@(posedge clk_i) finish && st_r.conv_clock_select);
  pin_trig_c:  cover property (@(posedge clk_i) trg_start && st_r.phase == sac_pkg::PH_IDLE);
  abort_c:     cover property (@(posedge clk_i) sw_abort && st_r.phase == sac_pkg::PH_CONV);

endmodule : sac_adc_ctrl

/* File: tb/sac_analog_model.sv */
// partner: behavioural comparator of the analog sampling core
`timescale 1ns/10ps
module sac_analog_model (
  // trial drive from the converter
  input  wire sac_pkg::sac_analog_type analog_i,
  // voltage of each input as a 10-bit code
  input  wire logic [2:0][9:0]         level_i,
  // comparator answer, 1 = input at or above trial
  output      logic                    comp_o
);
  // no selected input leaves the comparator low, not the last answer
  always_comb
  begin
    comp_o = 1'b0;
    for (int k = 0; k < 3; k++)
      if (analog_i.chan_sel[k])
        comp_o = (level_i[k] >= analog_i.trial);
  end
endmodule : sac_analog_model

/* File: tb/tb_sac_adc_ctrl.sv */
// testbench: register bus, conversions, trigger pin and retention of the converter control
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_sac_adc_ctrl;
  logic                    clk_i, sys_rst_i, hold_i, comp, pin, irq;
  logic                    awv, awr, wv, wr_r, bv, br, arv, arr, rv_v, rr;
  logic [31:0]             awa, wd, ara, rdat, rv;
  logic [1:0]              bresp, rresp, rs;
  sac_pkg::sac_analog_type ana;
  logic [2:0][9:0]         lv;
  logic [9:0]              keep;
  int                      n_mismatch, n_compared, seed, cyc;

  sac_adc_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hold_i(hold_i),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv_v), .s_axi_rready(rr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .comp_i(comp), .ext_trigger_pin_i(pin), .analog_o(ana),
    .conv_irq_o(irq));
  sac_analog_model core (.analog_i(ana), .level_i(lv), .comp_o(comp));

  // free clock and cycle count used to time conversions
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // handshakes read 1 ns after an edge, where they stand until the next edge samples them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    logic ta;
    logic tw;
    logic tk;
    @(posedge clk_i);
    awv <= 1'b1;
    awa <= {24'h0, a};
    wv  <= 1'b1;
    wd  <= {24'h0, d};
    br  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    do
    begin
      #1;
      ta = aw && (awr === 1'b1);
      tw = w && (wr_r === 1'b1);
      tk = (bv === 1'b1);
      rs = bresp;
      @(posedge clk_i);
      if (ta)
      begin
        aw = 1'b0;
        awv <= 1'b0;
      end
      if (tw)
      begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end while (!tk);
    br <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic tk;
    @(posedge clk_i);
    arv <= 1'b1;
    ara <= {24'h0, a};
    rr  <= 1'b1;
    do
    begin
      #1;
      tk = (arr === 1'b1);
      @(posedge clk_i);
    end while (!tk);
    arv <= 1'b0;
    do
    begin
      #1;
      tk = (rv_v === 1'b1);
      rv = rdat;
      rs = rresp;
      @(posedge clk_i);
    end while (!tk);
    rr <= 1'b0;
  endtask : rd

  task automatic chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, rv[7:0])
  endtask : chk

  // one software-started conversion; timing, flag, done and result checked
  task automatic conv(input logic c, input logic [3:0] ch);
    int         t0;
    int         lim;
    logic [2:0] es;
    es  = (ch == 4'h4) ? 3'h1 : (ch == 4'h5) ? 3'h2 : (ch == 4'h6) ? 3'h4 : 3'h0;
    lim = c ? int'(sac_pkg::STATES_FAST) : int'(sac_pkg::STATES_SLOW);
    for (int k = 0; k < 3; k++) lv[k] <= 10'($random(seed));
    wr(sac_pkg::MODE_OFS, {c, 3'h3, ch});
    wr(sac_pkg::START_OFS, 8'h80);
    t0 = cyc;
    #1 `CHK("chan_sel", es, ana.chan_sel)
    `CHK("sample", 1'b1, ana.sample)
    chk("flag_busy", sac_pkg::START_OFS, 8'hFF);
    while (irq !== 1'b1) @(posedge clk_i);
    `CHK("conv_len", 1'b1, (cyc - t0 >= lim) && (cyc - t0 <= lim + 1))
    chk("flag_end", sac_pkg::START_OFS, 8'h7F);
    chk("done_flag", sac_pkg::STAT_OFS, 8'h01);
    rd(sac_pkg::RESULT_OFS);
    if (es != 3'h0) `CHK("result", lv[ch[1:0]], rv[15:6])
    wr(sac_pkg::STAT_OFS, 8'h01);
    repeat (2) @(posedge clk_i);
    `CHK("irq_clr", 1'b0, irq)
    `CHK("sample_idle", 1'b0, ana.sample)
    `CHK("chan_idle", 3'h0, ana.chan_sel)
  endtask : conv

  task automatic end_sim;
    $display("counts: compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // watchdog, sized well beyond the thousand or so cycles the tests take
  initial
  begin
    #200000;
    n_mismatch++;
    $display("BAD watchdog exp done got hang");
    end_sim();
  end

  // main sequence
  initial
  begin
    logic [5:0][4:0] tbl;
    logic [4:0]      e;
    logic            hit;
    seed = 39803;
    cyc = 0;
    {awv, wv, br, arv, rr, hold_i, awa, wd, ara} = '0;
    lv = '0;
    pin = 1'b0;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk("mode_rst", sac_pkg::MODE_OFS, 8'h30);
    chk("start_rst", sac_pkg::START_OFS, 8'h7F);
    wr(sac_pkg::MODE_OFS, 8'h8C);
    `CHK("wr_resp", 2'b00, rs)
    chk("mode_rsvd", sac_pkg::MODE_OFS, 8'hBC);
    wr(sac_pkg::START_OFS, 8'h00);
    chk("start_rsvd", sac_pkg::START_OFS, 8'h7F);
    rd(8'h14);
    `CHK("unmap_resp", 2'b10, rs)
    `CHK("unmap_data", 32'h0, rv)
    wr(8'h14, 8'h00);
    `CHK("unmap_wresp", 2'b10, rs)
    hold_i <= 1'b1;
    wr(sac_pkg::MODE_OFS, 8'h05);
    chk("mode_hold", sac_pkg::MODE_OFS, 8'hBC);
    hold_i <= 1'b0;
    $display("test registers done");
    wr(sac_pkg::CTRL_OFS, 8'h04);
    // valid channel codes at both clock rates; codes 8 (slow) and 2 (fast) select no input
    for (int i = 0; i < 8; i++) conv(i[0], 4'((32'h2865_4654 >> (4 * i))));
    $display("test conversions done");
    wr(sac_pkg::MODE_OFS, 8'h04);
    wr(sac_pkg::START_OFS, 8'h80);
    repeat (5) @(posedge clk_i);
    wr(sac_pkg::START_OFS, 8'h00);
    chk("abort_flag", sac_pkg::START_OFS, 8'h7F);
    repeat (80) @(posedge clk_i);
    chk("abort_done", sac_pkg::STAT_OFS, 8'h00);
    $display("test abort done");
    // {trigger enable, pin select, polarity, new pin level, start expected}
    tbl = {5'b10100, 5'b11110, 5'b11101, 5'b11011, 5'b11000, 5'b01010};
    for (int i = 0; i < 6; i++)
    begin
      e = tbl[i];
      wr(sac_pkg::MODE_OFS, {1'b1, e[4], 6'h05});
      wr(sac_pkg::CTRL_OFS, {5'h0, 1'b1, e[3], e[2]});
      pin <= e[1];
      hit = 1'b0;
      repeat (60)
      begin
        @(posedge clk_i);
        hit |= (irq === 1'b1);
      end
      `CHK("trig_start", e[0], hit)
      wr(sac_pkg::STAT_OFS, 8'h01);
    end
    $display("test trigger done");
    rd(sac_pkg::RESULT_OFS);
    keep = rv[15:6];
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(sac_pkg::RESULT_OFS);
    `CHK("result_keep", keep, rv[15:6])
    chk("mode_rst2", sac_pkg::MODE_OFS, 8'h30);
    $display("test reset done");
    end_sim();
  end
endmodule : tb_sac_adc_ctrl
